//--- common/ldcd_pkg.sv
/*
  Constants and carrier types for the logical-device configuration and
  address decode block. Assumes one 8-bit host I/O cycle per request.
*/
package ldcd_pkg;
  localparam int          LDCD_NUM_DEV       = 12;
  // Global configuration indices
  localparam logic [7:0]  IDX_DEV_NUMBER     = 8'h07;
  localparam logic [7:0]  IDX_GLOBAL_OSC     = 8'h24;
  localparam logic [7:0]  IDX_CFG_ADDR_LOW   = 8'h26;
  localparam logic [7:0]  IDX_CFG_ADDR_HIGH  = 8'h27;
  localparam int          QUAL_ENABLE_BIT    = 6;
  // Per-device indices
  localparam logic [7:0]  IDX_ACTIVATE       = 8'h30;
  localparam logic [7:0]  IDX_IO_BASE_HIGH   = 8'h60;
  localparam logic [7:0]  IDX_IO_BASE_LOW    = 8'h61;
  localparam logic [7:0]  IDX_IRQ_LEVEL_SEL  = 8'h70;
  localparam logic [7:0]  IDX_DMA_CHAN_SEL   = 8'h74;
  // Configuration state keys, written to the index port
  localparam logic [7:0]  CFG_ENTER_KEY      = 8'h55;
  localparam logic [7:0]  CFG_EXIT_KEY       = 8'haa;
  // Power-up configuration port addresses
  localparam logic [15:0] CFG_BASE_STRAP_LOW  = 16'h002e;
  localparam logic [15:0] CFG_BASE_STRAP_HIGH = 16'h004e;
  // Reset values
  localparam logic [7:0]  IRQ_RESET_FLOPPY   = 8'h06;
  localparam logic [7:0]  IRQ_RESET_OTHER    = 8'h00;
  localparam logic [7:0]  DMA_RESET_FLOPPY   = 8'h02;
  localparam logic [7:0]  DMA_RESET_PARALLEL = 8'h04;
  localparam logic [7:0]  DMA_RESET_OTHER    = 8'h00;
  localparam logic [3:0]  IRQ_SEL_NONE       = 4'h0;
  localparam logic [3:0]  IRQ_SEL_SYS_MGMT   = 4'h2;
  // Logical device numbers
  localparam logic [3:0]  DEV_FLOPPY   = 4'h0;
  localparam logic [3:0]  DEV_PARALLEL = 4'h3;
  localparam logic [3:0]  DEV_SERIAL   = 4'h4;
  localparam logic [3:0]  DEV_MIDI     = 4'h5;
  localparam logic [3:0]  DEV_KEYBOARD = 4'h7;
  localparam logic [3:0]  DEV_GAME     = 4'h9;
  localparam logic [3:0]  DEV_RUNTIME  = 4'ha;
  localparam logic [3:0]  DEV_SMBUS    = 4'hb;
  // Base ranges and fixed addresses
  localparam logic [11:0] BASE_MIN_IO      = 12'h100;
  localparam logic [11:0] BASE_MAX_8B      = 12'hff8;
  localparam logic [11:0] BASE_MAX_4B      = 12'hffc;
  localparam logic [11:0] BASE_MAX_GAME    = 12'hfff;
  localparam logic [11:0] BASE_MIN_RUNTIME = 12'h000;
  localparam logic [11:0] BASE_MAX_RUNTIME = 12'hf7f;
  localparam logic [11:0] BASE_MAX_CFG     = 12'hffe;
  localparam logic [11:0] RUNTIME_LAST_OFS = 12'h06c;
  localparam logic [11:0] PAR_HIGH_OFS     = 12'h400;
  localparam logic [11:0] PAR_HIGH_LAST    = 12'h402;
  localparam logic [11:0] KBD_DATA_ADDR    = 12'h060;
  localparam logic [11:0] KBD_CMD_ADDR     = 12'h064;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } ldcd_io_req_type;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [3:0]  dev;
    logic [11:0] offset;
    logic [7:0]  wdata;
  } ldcd_claim_type;

  typedef enum logic [0:0] {
    LDCD_RUN    = 1'b0,
    LDCD_CONFIG = 1'b1
  } ldcd_state_type;
endpackage

//--- src/ldcd_config_decode.sv
/*
  Configuration registers and I/O address decode for the logical devices
  of a multi-function I/O chip. Assumes the bus interface delivers each
  host I/O cycle as a one-cycle request, synchronous to i_clk_sys.
*/
//
// Overview of operation
// RULE_01 - A device is active when its activate or power bit is set.
// RULE_02 - Activate and power bits are one linked bit; writing either sets both.
// RULE_03 - Host cycles to a device whose base lies out of range are ignored.
// RULE_04 - Floppy interrupt select resets to 0x06, all others to none.
// RULE_05 - DMA select resets to 0x02 for floppy, 0x04 for parallel.
// RULE_06 - Parallel base 0x100-0xffc on 4 bytes, or 0xff8 on 8 for all modes.
// RULE_07 - Game port base 0x100-0xfff on any byte, one register at +0.
// RULE_08 - Keyboard is fixed: data at 0x60, command and status at 0x64.
// RULE_09 - Runtime base 0x000-0xf7f on 128 bytes, offsets 0 through 0x6c.
// RULE_10 - Config port: index at base, data at base+1, 2-byte aligned.
// RULE_11 - Bases decode from host address bits 11 down to 0.
// RULE_12 - With global bit 6 set, address bits 15 to 12 must be zero.
// RULE_13 - Config port starts at 0x02e or 0x04e from the strap.
// RULE_14 - Interrupt select low nibble: 0 none, 1-15 line, 2 also system line.
// RULE_15 - Interrupts are active-high edges, parallel extended modes inverted.
// RULE_16 - System management interrupt output is active low.
// RULE_17 - Base high byte at index 0x60, low byte at index 0x61.
// RULE_18 - Device registers reach the host only in configuration state.
// RULE_19 - A cycle is claimed only by an active device at base plus offset.
`timescale 1ns/10ps
`default_nettype none
module ldcd_config_decode
  import ldcd_pkg::*;
#(
  parameter int NUM_DEV = LDCD_NUM_DEV
) (
  input  wire logic            i_clk_sys,
  input  wire logic            i_reset_n,
  input  wire logic            i_config_port_strap,
  input  wire ldcd_io_req_type i_io_req,
  input  wire logic            i_pwr_wr,
  input  wire logic [3:0]      i_pwr_dev,
  input  wire logic            i_pwr_value,
  input  wire logic [NUM_DEV-1:0] i_dev_irq,
  input  wire logic            i_par_ext_mode,
  output ldcd_claim_type       o_claim,
  output logic                 o_cfg_rd_valid,
  output logic [7:0]           o_cfg_rd_data,
  output logic                 o_config_state,
  output logic [NUM_DEV-1:0]   o_dev_active,
  output logic                 o_par_ext_allowed,
  output logic [15:1]          o_irq_lines,
  output logic                 o_sys_mgmt_irq_n
);

  ldcd_state_type          state_q;
  logic                    strap_loaded_q;
  logic [7:0]              dev_num_q;
  logic [7:0]              global_osc_q;
  logic [15:0]             cfg_base_q;
  logic [7:0]              index_q;
  logic [NUM_DEV-1:0]      active_q;
  logic [15:0]             base_q [NUM_DEV];
  logic [7:0]              irq_sel_q [NUM_DEV];
  logic [7:0]              dma_sel_q [NUM_DEV];

  logic [11:0]             addr12;
  logic                    upper_ok;
  logic                    cfg_index_hit;
  logic                    cfg_data_hit;
  logic                    data_wr;
  logic                    dev_sel_ok;
  logic [3:0]              cur_dev;
  logic [NUM_DEV-1:0]      base_ok;
  logic [NUM_DEV-1:0]      dev_hit;
  logic [11:0]             dev_ofs [NUM_DEV];
  logic [7:0]              cfg_rd_d;
  logic                    par_ext_ok;
  logic [NUM_DEV-1:0]      dev_req;
  logic [15:0]             irq_lvl_d;

  // Host address checks
  assign addr12   = i_io_req.addr[11:0];                          // RULE_11
  assign upper_ok = !global_osc_q[QUAL_ENABLE_BIT] ||
                    (i_io_req.addr[15:12] == 4'h0);               // RULE_12
  assign cfg_index_hit = i_io_req.valid && upper_ok &&
                         (addr12 == cfg_base_q[11:0]);            // RULE_10
  assign cfg_data_hit  = i_io_req.valid && upper_ok &&
                         (addr12 == cfg_base_q[11:0] + 12'h001);  // RULE_10
  assign cur_dev    = dev_num_q[3:0];
  assign dev_sel_ok = (dev_num_q < 8'(NUM_DEV));
  assign data_wr    = cfg_data_hit && i_io_req.write &&
                      (state_q == LDCD_CONFIG);                   // RULE_18

  // Range and alignment of each programmed base
  always_comb begin
    for (int d = 0; d < NUM_DEV; d++) begin
      base_ok[d] = 1'b0;
      case (4'(d))
        DEV_FLOPPY, DEV_SERIAL, DEV_MIDI, DEV_SMBUS: begin
          base_ok[d] = base_q[d][15:12] == 4'h0 &&
                       base_q[d][11:0] >= BASE_MIN_IO &&
                       base_q[d][11:0] <= BASE_MAX_8B &&
                       base_q[d][2:0] == 3'h0;
        end
        DEV_PARALLEL: begin
          base_ok[d] = base_q[d][15:12] == 4'h0 &&
                       base_q[d][11:0] >= BASE_MIN_IO &&
                       base_q[d][11:0] <= BASE_MAX_4B &&
                       base_q[d][1:0] == 2'h0;                    // RULE_06
        end
        DEV_GAME: begin
          base_ok[d] = base_q[d][15:12] == 4'h0 &&
                       base_q[d][11:0] >= BASE_MIN_IO &&
                       base_q[d][11:0] <= BASE_MAX_GAME;          // RULE_07
        end
        DEV_RUNTIME: begin
          base_ok[d] = base_q[d][15:12] == 4'h0 &&
                       base_q[d][11:0] >= BASE_MIN_RUNTIME &&
                       base_q[d][11:0] <= BASE_MAX_RUNTIME &&
                       base_q[d][6:0] == 7'h00;                   // RULE_09
        end
        DEV_KEYBOARD: begin
          base_ok[d] = 1'b1;                                      // RULE_08
        end
        default: begin
          base_ok[d] = 1'b0;
        end
      endcase
    end
  end

  // Extended offsets follow the live base, so a claim and the
  // registered status flag always agree on the same cycle
  assign par_ext_ok = base_ok[DEV_PARALLEL] &&
                      base_q[DEV_PARALLEL][11:0] <= BASE_MAX_8B &&
                      base_q[DEV_PARALLEL][2:0] == 3'h0;          // RULE_06

  // Per-device address match; offsets wrap within twelve bits
  always_comb begin
    for (int d = 0; d < NUM_DEV; d++) begin
      dev_ofs[d] = addr12 - base_q[d][11:0];
      dev_hit[d] = 1'b0;
      case (4'(d))
        DEV_FLOPPY: begin
          dev_hit[d] = dev_ofs[d] <= 12'h007 && dev_ofs[d] != 12'h006;
        end
        DEV_PARALLEL: begin
          dev_hit[d] = dev_ofs[d] <= 12'h002 ||
                       (dev_ofs[d] <= 12'h007 && par_ext_ok) ||
                       (dev_ofs[d] >= PAR_HIGH_OFS &&
                        dev_ofs[d] <= PAR_HIGH_LAST);             // RULE_06
        end
        DEV_SERIAL: begin
          dev_hit[d] = dev_ofs[d] <= 12'h007;
        end
        DEV_MIDI: begin
          dev_hit[d] = dev_ofs[d] <= 12'h001;
        end
        DEV_SMBUS: begin
          dev_hit[d] = dev_ofs[d] <= 12'h003;
        end
        DEV_GAME: begin
          dev_hit[d] = dev_ofs[d] == 12'h000;                     // RULE_07
        end
        DEV_RUNTIME: begin
          dev_hit[d] = dev_ofs[d] <= RUNTIME_LAST_OFS;            // RULE_09
        end
        DEV_KEYBOARD: begin
          dev_ofs[d] = addr12 - KBD_DATA_ADDR;
          dev_hit[d] = addr12 == KBD_DATA_ADDR ||
                       addr12 == KBD_CMD_ADDR;                    // RULE_08
        end
        default: begin
          dev_hit[d] = 1'b0;
        end
      endcase
      // Inactive devices and out-of-range bases never claim a cycle
      dev_hit[d] = dev_hit[d] && active_q[d] && base_ok[d];       // RULE_03 RULE_19
    end
  end

  // Configuration state and index register
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= LDCD_RUN;
      index_q <= 8'h00;
    end else if (cfg_index_hit && i_io_req.write) begin
      if (state_q == LDCD_RUN) begin
        if (i_io_req.wdata == CFG_ENTER_KEY) begin
          state_q <= LDCD_CONFIG;
        end
      end else if (i_io_req.wdata == CFG_EXIT_KEY) begin
        state_q <= LDCD_RUN;
      end else begin
        index_q <= i_io_req.wdata;
      end
    end
  end

  // Global registers; strap is caught on the first edge after release
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      strap_loaded_q <= 1'b0;
      cfg_base_q     <= 16'h0000;
      dev_num_q      <= 8'h00;
      global_osc_q   <= 8'h00;
    end else if (!strap_loaded_q) begin
      strap_loaded_q <= 1'b1;
      cfg_base_q     <= i_config_port_strap ? CFG_BASE_STRAP_HIGH
                                            : CFG_BASE_STRAP_LOW; // RULE_13
    end else if (data_wr) begin
      case (index_q)
        IDX_DEV_NUMBER:    dev_num_q <= i_io_req.wdata;
        IDX_GLOBAL_OSC:    global_osc_q <= i_io_req.wdata;        // RULE_12
        // Bit 0 forced low keeps the port on a 2-byte boundary
        IDX_CFG_ADDR_LOW:  cfg_base_q[7:0] <= {i_io_req.wdata[7:1], 1'b0}; // RULE_10
        IDX_CFG_ADDR_HIGH: cfg_base_q[15:8] <= i_io_req.wdata;    // RULE_13
        default: begin
        end
      endcase
    end
  end

  // Per-device registers
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      active_q <= '0;
      for (int d = 0; d < NUM_DEV; d++) begin
        base_q[d]    <= 16'h0000;
        irq_sel_q[d] <= (4'(d) == DEV_FLOPPY) ? IRQ_RESET_FLOPPY
                                              : IRQ_RESET_OTHER;  // RULE_04
        dma_sel_q[d] <= (4'(d) == DEV_FLOPPY)   ? DMA_RESET_FLOPPY :
                        (4'(d) == DEV_PARALLEL) ? DMA_RESET_PARALLEL :
                                                  DMA_RESET_OTHER; // RULE_05
      end
    end else begin
      // One stored bit serves as both activate and power control
      if (i_pwr_wr && i_pwr_dev < 4'(NUM_DEV)) begin
        active_q[i_pwr_dev] <= i_pwr_value;                       // RULE_02
      end
      if (data_wr && dev_sel_ok) begin
        case (index_q)
          IDX_ACTIVATE:      active_q[cur_dev] <= i_io_req.wdata[0]; // RULE_02
          IDX_IO_BASE_HIGH:  base_q[cur_dev][15:8] <= i_io_req.wdata; // RULE_17
          IDX_IO_BASE_LOW:   base_q[cur_dev][7:0] <= i_io_req.wdata;  // RULE_17
          IDX_IRQ_LEVEL_SEL: irq_sel_q[cur_dev] <= {4'h0, i_io_req.wdata[3:0]};
          IDX_DMA_CHAN_SEL:  dma_sel_q[cur_dev] <= {5'h00, i_io_req.wdata[2:0]};
          default: begin
          end
        endcase
      end
    end
  end

  // Configuration read data
  always_comb begin
    cfg_rd_d = 8'h00;
    if (cfg_index_hit) begin
      cfg_rd_d = index_q;
    end else if (state_q == LDCD_CONFIG) begin                    // RULE_18
      case (index_q)
        IDX_DEV_NUMBER:    cfg_rd_d = dev_num_q;
        IDX_GLOBAL_OSC:    cfg_rd_d = global_osc_q;
        IDX_CFG_ADDR_LOW:  cfg_rd_d = cfg_base_q[7:0];
        IDX_CFG_ADDR_HIGH: cfg_rd_d = cfg_base_q[15:8];
        IDX_ACTIVATE:      cfg_rd_d = dev_sel_ok ? {7'h00, active_q[cur_dev]} : 8'h00;
        IDX_IO_BASE_HIGH:  cfg_rd_d = dev_sel_ok ? base_q[cur_dev][15:8] : 8'h00;
        IDX_IO_BASE_LOW:   cfg_rd_d = dev_sel_ok ? base_q[cur_dev][7:0] : 8'h00;
        IDX_IRQ_LEVEL_SEL: cfg_rd_d = dev_sel_ok ? irq_sel_q[cur_dev] : 8'h00;
        IDX_DMA_CHAN_SEL:  cfg_rd_d = dev_sel_ok ? dma_sel_q[cur_dev] : 8'h00;
        default:           cfg_rd_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_cfg_rd_valid <= 1'b0;
      o_cfg_rd_data  <= 8'h00;
    end else begin
      o_cfg_rd_valid <= (cfg_index_hit || cfg_data_hit) && !i_io_req.write;
      o_cfg_rd_data  <= cfg_rd_d;
    end
  end

  // Claim of a host cycle; lowest device number wins an overlap
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_claim <= '0;
    end else begin
      o_claim <= '0;
      if (i_io_req.valid && upper_ok && !cfg_index_hit && !cfg_data_hit) begin
        for (int d = NUM_DEV - 1; d >= 0; d--) begin
          if (dev_hit[d]) begin
            o_claim.valid  <= 1'b1;                               // RULE_19
            o_claim.write  <= i_io_req.write;
            o_claim.dev    <= 4'(d);
            o_claim.offset <= dev_ofs[d];
            o_claim.wdata  <= i_io_req.wdata;
          end
        end
      end
    end
  end

  // Status outputs
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_config_state    <= 1'b0;
      o_dev_active      <= '0;
      o_par_ext_allowed <= 1'b0;
    end else begin
      o_config_state    <= (state_q == LDCD_CONFIG);
      o_dev_active      <= active_q;                              // RULE_01
      o_par_ext_allowed <= par_ext_ok;                            // RULE_06
    end
  end

  // Interrupt routing; a level of zero routes nowhere
  always_comb begin
    dev_req = i_dev_irq;
    // Extended parallel modes present their request inverted
    if (i_par_ext_mode) begin
      dev_req[DEV_PARALLEL] = !i_dev_irq[DEV_PARALLEL];           // RULE_15
    end
    irq_lvl_d = '0;
    for (int d = 0; d < NUM_DEV; d++) begin
      if (active_q[d] && dev_req[d] &&
          irq_sel_q[d][3:0] != IRQ_SEL_NONE) begin
        irq_lvl_d[irq_sel_q[d][3:0]] = 1'b1;                      // RULE_14
      end
    end
  end

  // Level two feeds both the shared line and the active-low system line
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_irq_lines      <= '0;
      o_sys_mgmt_irq_n <= 1'b1;
    end else begin
      o_irq_lines      <= irq_lvl_d[15:1];                        // RULE_15
      o_sys_mgmt_irq_n <= !irq_lvl_d[IRQ_SEL_SYS_MGMT]; // RULE_14 RULE_16
    end
  end

endmodule
`default_nettype wire

//--- test/ldcd_config_decode_properties.sv
/*
  Port-level assertions for the configuration and decode block.
  Assumes it is bound to ldcd_config_decode and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none
module ldcd_checker
  import ldcd_pkg::*;
#(
  parameter int NUM_DEV = LDCD_NUM_DEV
) (
  input wire logic               i_clk_sys,
  input wire logic               i_reset_n,
  input wire logic               i_config_port_strap,
  input wire ldcd_io_req_type    i_io_req,
  input wire logic               i_pwr_wr,
  input wire logic [3:0]         i_pwr_dev,
  input wire logic               i_pwr_value,
  input wire logic [NUM_DEV-1:0] i_dev_irq,
  input wire logic               i_par_ext_mode,
  input wire ldcd_claim_type     o_claim,
  input wire logic               o_cfg_rd_valid,
  input wire logic [7:0]         o_cfg_rd_data,
  input wire logic               o_config_state,
  input wire logic [NUM_DEV-1:0] o_dev_active,
  input wire logic               o_par_ext_allowed,
  input wire logic [15:1]        o_irq_lines,
  input wire logic               o_sys_mgmt_irq_n
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  claim_cause_a: assert property (
    o_claim.valid |-> $past(i_io_req.valid) && o_claim.write ==
    $past(i_io_req.write)) else $error("claim without request");
  claim_active_a: assert property (
    o_claim.valid |-> o_dev_active[o_claim.dev])
    else $error("claim by inactive device");
  kbd_fixed_a: assert property (
    o_claim.valid && o_claim.dev == DEV_KEYBOARD |-> o_claim.offset inside
    {12'h000, 12'h004} && $past(i_io_req.addr[11:0]) ==
    KBD_DATA_ADDR + o_claim.offset) else $error("keyboard decode wrong");
  game_single_a: assert property (
    o_claim.valid && o_claim.dev == DEV_GAME |-> o_claim.offset == 12'h000)
    else $error("game port offset not zero");
  runtime_span_a: assert property (
    o_claim.valid && o_claim.dev == DEV_RUNTIME |->
    o_claim.offset <= RUNTIME_LAST_OFS) else $error("runtime offset too big");
  par_ext_a: assert property (
    o_claim.valid && o_claim.dev == DEV_PARALLEL && o_claim.offset inside
    {[12'h003:12'h007]} |-> o_par_ext_allowed)
    else $error("parallel extended offset on 4-byte base");
  cfg_read_a: assert property (
    o_cfg_rd_valid |-> $past(i_io_req.valid && !i_io_req.write))
    else $error("config read answer without read");
  cfg_enter_a: assert property (
    $rose(o_config_state) |-> $past(i_io_req.valid && i_io_req.write &&
    i_io_req.wdata == CFG_ENTER_KEY, 2))
    else $error("config entered without key");
  smi_pair_a: assert property (
    !o_sys_mgmt_irq_n |-> o_irq_lines[2])
    else $error("system line without level two");
  smi_cause_a: assert property (
    $fell(o_sys_mgmt_irq_n) |-> $past(|i_dev_irq || i_par_ext_mode))
    else $error("system line low without request");
endmodule
bind ldcd_config_decode ldcd_checker #(.NUM_DEV(NUM_DEV)) u_chk (
  .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
  .i_config_port_strap(i_config_port_strap), .i_io_req(i_io_req),
  .i_pwr_wr(i_pwr_wr), .i_pwr_dev(i_pwr_dev), .i_pwr_value(i_pwr_value),
  .i_dev_irq(i_dev_irq), .i_par_ext_mode(i_par_ext_mode),
  .o_claim(o_claim), .o_cfg_rd_valid(o_cfg_rd_valid),
  .o_cfg_rd_data(o_cfg_rd_data), .o_config_state(o_config_state),
  .o_dev_active(o_dev_active), .o_par_ext_allowed(o_par_ext_allowed),
  .o_irq_lines(o_irq_lines), .o_sys_mgmt_irq_n(o_sys_mgmt_irq_n));
`default_nettype wire

//--- test/ldcd_host_model.sv
/*
  Host-side model issuing one-cycle I/O requests to the decode block.
  Assumes the caller steps it from the bench clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module ldcd_host_model
  import ldcd_pkg::*;
(
  input  wire logic          i_clk_sys,
  output var ldcd_io_req_type o_io_req
);
  initial o_io_req = '0;
  // Idle lines show the inverse of the last value, never a stale copy
  task cyc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    o_io_req <= {1'b1, w, a, d};
    @(posedge i_clk_sys);
    o_io_req <= {1'b0, ~w, ~a, ~d};
  endtask
endmodule
`default_nettype wire

//--- test/tb.sv
/*
  Self-checking bench for the configuration and decode block.
  Assumes the host model and the bound checker are compiled alongside.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ldcd_pkg::*;
  logic            i_clk_sys = 1'b0;
  logic            i_reset_n = 1'b0;
  logic            strap     = 1'b1;
  logic            pwr_wr    = 1'b0;
  logic [3:0]      pwr_dev   = 4'h0;
  logic            pwr_val   = 1'b0;
  logic [11:0]     irq       = 12'h000;
  logic            ext       = 1'b0;
  ldcd_io_req_type req;
  ldcd_claim_type  claim;
  logic            rd_v, cfg_st, par_ok, smi_n;
  logic [7:0]      rd_d;
  logic [11:0]     act;
  logic [15:1]     lines;
  logic [15:0]     cp = 16'h004e;
  logic [8:0]      v;
  int              err_total = 0;
  int              comparisons = 0;
  always #20 i_clk_sys = ~i_clk_sys;
  ldcd_host_model u_host (.i_clk_sys(i_clk_sys), .o_io_req(req));
  ldcd_config_decode u_dut (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_config_port_strap(strap), .i_io_req(req), .i_pwr_wr(pwr_wr),
    .i_pwr_dev(pwr_dev), .i_pwr_value(pwr_val), .i_dev_irq(irq),
    .i_par_ext_mode(ext), .o_claim(claim), .o_cfg_rd_valid(rd_v),
    .o_cfg_rd_data(rd_d), .o_config_state(cfg_st), .o_dev_active(act),
    .o_par_ext_allowed(par_ok), .o_irq_lines(lines),
    .o_sys_mgmt_irq_n(smi_n));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [16:0] hit();
    return {claim.valid, claim.dev, claim.offset};
  endfunction
  // Outputs are sampled 1 ns after the edge that answers
  task acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    u_host.cyc(w, a, d);
    #1;
  endtask
  task cw(input logic [7:0] i, input logic [7:0] d);
    acc(1'b1, cp, i);
    acc(1'b1, cp + 16'h0001, d);
  endtask
  task cr(input logic [7:0] i, output logic [8:0] r);
    acc(1'b1, cp, i);
    acc(1'b0, cp + 16'h0001, 8'h00);
    r = {rd_v, rd_d};
  endtask
  task base(input logic [3:0] dv, input logic [15:0] b);
    cw(IDX_DEV_NUMBER, {4'h0, dv});
    cw(IDX_IO_BASE_HIGH, b[15:8]);
    cw(IDX_IO_BASE_LOW, b[7:0]);
    cw(IDX_ACTIVATE, 8'h01);
  endtask
  task settle;
    repeat (2) @(posedge i_clk_sys);
    #1;
  endtask
  task do_reset(input logic s);
    @(posedge i_clk_sys);
    i_reset_n <= 1'b0;
    strap     <= s;
    repeat (6) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
  endtask
  task t_defaults;
    acc(1'b1, cp, CFG_ENTER_KEY);
    settle();
    chk(cfg_st, 1'b1);
    cr(IDX_IRQ_LEVEL_SEL, v);
    chk(v, {1'b1, IRQ_RESET_FLOPPY});
    cr(IDX_DMA_CHAN_SEL, v);
    chk(v, {1'b1, DMA_RESET_FLOPPY});
    cw(IDX_DEV_NUMBER, 8'h03);
    cr(IDX_DMA_CHAN_SEL, v);
    chk(v, {1'b1, DMA_RESET_PARALLEL});
    cw(IDX_DEV_NUMBER, 8'h04);
    cr(IDX_IRQ_LEVEL_SEL, v);
    chk(v, {1'b1, IRQ_RESET_OTHER});
    $display("defaults test done");
  endtask
  task t_power;
    @(posedge i_clk_sys);
    pwr_wr  <= 1'b1;
    pwr_dev <= DEV_PARALLEL;
    pwr_val <= 1'b1;
    @(posedge i_clk_sys);
    pwr_wr <= 1'b0;
    settle();
    chk(act[3], 1'b1);
    cw(IDX_DEV_NUMBER, 8'h03);
    cr(IDX_ACTIVATE, v);
    chk(v, 9'h101);
    cw(IDX_ACTIVATE, 8'h00);
    settle();
    chk(act[3], 1'b0);
    $display("power test done");
  endtask
  task t_parallel;
    base(DEV_PARALLEL, 16'h0104);
    acc(1'b0, 16'h0105, 8'h00);
    chk(hit(), {1'b1, DEV_PARALLEL, 12'h001});
    chk(par_ok, 1'b0);
    acc(1'b0, 16'h0107, 8'h00);
    chk(claim.valid, 1'b0);
    acc(1'b0, 16'h0504, 8'h00);
    chk(hit(), {1'b1, DEV_PARALLEL, 12'h400});
    base(DEV_PARALLEL, 16'h0108);
    acc(1'b0, 16'h010b, 8'h00);
    chk(hit(), {1'b1, DEV_PARALLEL, 12'h003});
    base(DEV_PARALLEL, 16'h0ffc);
    acc(1'b0, 16'h0ffe, 8'h00);
    chk(hit(), {1'b1, DEV_PARALLEL, 12'h002});
    base(DEV_PARALLEL, 16'h00f8);
    acc(1'b0, 16'h00f8, 8'h00);
    chk(claim.valid, 1'b0);
    $display("parallel test done");
  endtask
  task t_fixed;
    cw(IDX_DEV_NUMBER, {4'h0, DEV_KEYBOARD});
    cw(IDX_ACTIVATE, 8'h01);
    acc(1'b0, 16'h0064, 8'h00);
    chk(hit(), {1'b1, DEV_KEYBOARD, 12'h004});
    acc(1'b0, 16'h0061, 8'h00);
    chk(claim.valid, 1'b0);
    base(DEV_GAME, 16'h0fff);
    acc(1'b0, 16'h1fff, 8'h00);
    chk(hit(), {1'b1, DEV_GAME, 12'h000});
    cw(IDX_GLOBAL_OSC, 8'h40);
    acc(1'b0, 16'h1fff, 8'h00);
    chk(claim.valid, 1'b0);
    acc(1'b1, 16'h0fff, 8'h5a);
    chk({hit(), claim.wdata}, {1'b1, DEV_GAME, 12'h000, 8'h5a});
    cw(IDX_GLOBAL_OSC, 8'h00);
    base(DEV_RUNTIME, 16'h0f00);
    acc(1'b0, 16'h0f6c, 8'h00);
    chk(hit(), {1'b1, DEV_RUNTIME, 12'h06c});
    acc(1'b0, 16'h0f6d, 8'h00);
    chk(claim.valid, 1'b0);
    $display("fixed and game test done");
  endtask
  task t_irq;
    cw(IDX_DEV_NUMBER, {4'h0, DEV_SERIAL});
    cw(IDX_ACTIVATE, 8'h01);
    cw(IDX_IRQ_LEVEL_SEL, 8'h02);
    @(posedge i_clk_sys);
    irq[4] <= 1'b1;
    settle();
    chk({lines[2], smi_n}, 2'b10);
    cw(IDX_IRQ_LEVEL_SEL, 8'h0f);
    settle();
    chk({lines, smi_n}, {15'h4000, 1'b1});
    cw(IDX_IRQ_LEVEL_SEL, 8'h00);
    settle();
    chk(lines, 15'h0000);
    cw(IDX_DEV_NUMBER, {4'h0, DEV_PARALLEL});
    cw(IDX_IRQ_LEVEL_SEL, 8'h05);
    @(posedge i_clk_sys);
    irq[4] <= 1'b0;
    ext    <= 1'b1;
    settle();
    chk(lines, 15'h0010);
    @(posedge i_clk_sys);
    ext <= 1'b0;
    settle();
    chk(lines, 15'h0000);
    $display("interrupt test done");
  endtask
  task t_reloc_exit;
    cw(IDX_CFG_ADDR_HIGH, 8'h02);
    cp = 16'h024e;
    cw(IDX_CFG_ADDR_LOW, 8'h00);
    cp = 16'h0200;
    cr(IDX_CFG_ADDR_LOW, v);
    chk(v, 9'h100);
    acc(1'b0, 16'h004f, 8'h00);
    chk(rd_v, 1'b0);
    acc(1'b1, cp, CFG_EXIT_KEY);
    settle();
    chk(cfg_st, 1'b0);
    cr(IDX_IRQ_LEVEL_SEL, v);
    chk(v, 9'h100);
    do_reset(1'b0);
    cp = 16'h002e;
    acc(1'b1, cp, CFG_ENTER_KEY);
    settle();
    chk(cfg_st, 1'b1);
    cr(IDX_IRQ_LEVEL_SEL, v);
    chk(v, {1'b1, IRQ_RESET_FLOPPY});
    $display("relocate and exit test done");
  endtask
  initial begin
    repeat (6) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    t_defaults();
    t_power();
    t_parallel();
    t_fixed();
    t_irq();
    t_reloc_exit();
    end_sim();
  end
  // A hang is cut short and counted as a mismatch
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    err_total++;
    end_sim();
  end
endmodule
`default_nettype wire
